// ==== logic/arch_regs_cfg.svh ====
// Register map offsets, field positions and reset values of the register set
`ifndef ARCH_REGS_CFG_SVH
`define ARCH_REGS_CFG_SVH
// Software port offsets (word index on a 6-bit address)
`define GPR_BASE        6'h00
`define SEG_BASE        6'h08
`define IPTR_OFF        6'h0e
`define MODE_OFF        6'h0f
`define FSW_OFF         6'h10
`define FCW_OFF         6'h11
`define FTW_OFF         6'h12
`define FPR_BASE        6'h20
// Float register fields
`define FP_SIGN_BIT     79
`define FP_EXP_MSB      78
`define FP_EXP_LSB      64
`define FP_MAN_MSB      63
// Reset values
`define GPR_RST         32'h0000_0000
`define SEG_RST         16'h0000
`define IPTR_RST        32'h0000_0000
`define FCW_RST         16'h0000
`define FSW_RST         16'h0000
`define FTW_RST         16'hffff
`define FPR_RST         80'h0
`endif

// ==== logic/arch_regs_pkg.sv ====
// Types shared by the architectural register set
package arch_regs_pkg;
    // Operand size of a general register access
    typedef enum logic [1:0] {
        sz_byte_lo,
        sz_byte_hi,
        sz_word,
        sz_dword
    } opsize_e;
    // Integer register numbers
    typedef enum logic [2:0] {
        accumulator_dword,
        count_reg,
        io_data_reg,
        general_pointer_reg,
        stack_top_pointer,
        stack_frame_pointer,
        source_index_reg,
        dest_index_reg
    } gpr_e;
    // Segment register numbers
    typedef enum logic [2:0] {
        extra_data_segment,
        code_segment,
        stack_segment,
        data_segment,
        third_data_segment,
        fourth_data_segment
    } seg_e;
    // Access purpose driving segment choice
    typedef enum logic [1:0] {
        use_fetch,
        use_stack,
        use_src,
        use_dst
    } ref_kind_e;
    // Instruction pointer update kinds
    typedef enum logic [1:0] {
        ip_hold,
        ip_advance,
        ip_transfer
    } ip_op_e;
    typedef logic [79:0] fpr_t;
endpackage : arch_regs_pkg

// ==== logic/seg_xlate_if.sv ====
// Segment translation request and answer bundle
interface seg_xlate_if;
    logic        prot_mode;
    logic [15:0] seg_value;
    logic [31:0] offset;
    logic [31:0] desc_base;
    logic [31:0] desc_limit;
    logic [7:0]  desc_attr;
    logic [12:0] desc_index;
    logic [31:0] lin_addr;
    logic        limit_fault;
    modport requester (output prot_mode, output seg_value, output offset, output desc_base,
                       output desc_limit, output desc_attr, input desc_index, input lin_addr,
                       input limit_fault);
    modport translator (input prot_mode, input seg_value, input offset, input desc_base,
                        input desc_limit, input desc_attr, output desc_index, output lin_addr,
                        output limit_fault);
endinterface : seg_xlate_if

// ==== logic/seg_xlate.sv ====
// Combinational segment base and linear address derivation
module seg_xlate (
    seg_xlate_if.translator x
);
    // Real mode: base is value times 16; protected: selector picks descriptor
    always_comb begin
        x.desc_index  = x.seg_value[15:3];
        if (x.prot_mode) begin
            x.lin_addr    = x.desc_base + x.offset;
            x.limit_fault = (x.offset > x.desc_limit) || !x.desc_attr[7]; // Present bit gate
        end else begin
            x.lin_addr    = {12'h000, x.seg_value, 4'h0} + x.offset;
            x.limit_fault = 1'b0;
        end
    end
endmodule : seg_xlate

// ==== logic/gpr_merge.sv ====
// Sub-register view read and merge helper for one general register
module gpr_merge
    import arch_regs_pkg::*;
(
    // Register and access
    input  wire logic [31:0] cur,
    input  wire logic [31:0] wdata,
    input  wire opsize_e     size,
    // Results
    output logic [31:0]      merged,
    output logic [31:0]      view
);
    // Narrow writes touch only the overlaid bits
    always_comb begin
        merged = cur;
        view   = cur;
        case (size)
            sz_byte_lo: begin
                merged[7:0] = wdata[7:0];
                view        = {24'h000000, cur[7:0]};
            end
            sz_byte_hi: begin
                merged[15:8] = wdata[7:0];
                view         = {24'h000000, cur[15:8]};
            end
            sz_word: begin
                merged[15:0] = wdata[15:0];
                view         = {16'h0000, cur[15:0]};
            end
            default: begin
                merged = wdata;
                view   = cur;
            end
        endcase
    end
endmodule : gpr_merge

// ==== logic/arch_regs.sv ====
// Architectural register set: integer, segment, pointer and float registers
//
// Overview of operation
// - Eight 32-bit general registers for data
// - Four registers have word and byte views
// - Word view is low 16 bits, shared
// - Two byte views split each word view
// - Index and stack registers: word view only
// - Byte, word, dword, quadword integer operands; quadword only as a gpr_pair read, pair writes copy 32 bits to both
// - Six 16-bit segment registers
// - Code fetch, stack and data segment roles
// - Real mode base comes from segment value
// - Protected mode value selects a descriptor
// - Instruction pointer, 32-bit or 16-bit form
// - Pointer changes only by advance or control transfer
// - Float data plus status, control, tag words
// - Eight 80-bit float registers, zero to seven
// - Sign 79, exponent 78:64, significand 63:0
// - 16-bit float status word shows state
// - Software-writable float control word
// - Index and stack pointers pick their segments; stack_frame_pointer has no reference kind and picks none
// - Tag word describes each stack entry
//
// Implementation choices: the placing of the registers and the plain strobed port.
`include "arch_regs_cfg.svh"
module arch_regs (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic                   clk_en,
    // Software register port
    input  wire logic [5:0]             sw_addr,
    input  wire logic [31:0]            sw_wdata,
    input  wire logic                   sw_wr,
    input  wire logic                   sw_rd,
    output logic [31:0]                 sw_rdata,
    // Integer register read/write port
    input  wire logic [2:0]             gpr_sel,
    input  wire arch_regs_pkg::opsize_e gpr_size,
    input  wire logic                   gpr_wr,
    input  wire logic [31:0]            gpr_wdata,
    input  wire logic                   gpr_pair,
    output logic [63:0]                 gpr_rdata,
    // Segment registers
    input  wire logic [2:0]             seg_sel,
    input  wire logic                   seg_wr,
    input  wire logic [15:0]            seg_wdata,
    // Address generation
    input  wire arch_regs_pkg::ref_kind_e ref_kind,
    input  wire logic [31:0]            desc_base,
    input  wire logic [31:0]            desc_limit,
    input  wire logic [7:0]             desc_attr,
    output logic [31:0]                 lin_addr,
    output logic [12:0]                 desc_index,
    output logic                        addr_fault,
    // Instruction pointer
    input  wire arch_regs_pkg::ip_op_e  ip_op,
    input  wire logic [3:0]             ip_len,
    input  wire logic [31:0]            ip_target,
    output logic [31:0]                 fetch_addr,
    // Float unit
    input  wire logic [2:0]             fpr_sel,
    input  wire logic                   fpr_wr,
    input  wire arch_regs_pkg::fpr_t    fpr_wdata,
    output arch_regs_pkg::fpr_t         fpr_rdata,
    input  wire logic                   fsw_wr,
    input  wire logic [15:0]            fsw_wdata,
    input  wire logic                   ftw_wr,
    input  wire logic [15:0]            ftw_wdata,
    output logic [15:0]                 fcw_out
);
    import arch_regs_pkg::*;

    logic [31:0] gpr_q [8];
    logic [15:0] seg_q [6];
    fpr_t        fpr_q [8];
    logic [31:0] ip_q;
    logic        prot_q;
    logic        op32_q;
    logic [15:0] fsw_q;
    logic [15:0] fcw_q;
    logic [15:0] ftw_q;

    // Byte views exist only on the first four registers
    function automatic opsize_e legal_size(input logic [2:0] sel, input opsize_e sz);
        if (sel >= 3'd4 && (sz == sz_byte_lo || sz == sz_byte_hi)) begin
            return sz_word;
        end
        return sz;
    endfunction : legal_size

    // Address decode helper shared by read and write
    function automatic logic in_range(input logic [5:0] a, input logic [5:0] base, input logic [5:0] n);
        return (a >= base) && (a < base + n);
    endfunction : in_range

    // Merge for execution-unit writes
    logic [31:0] gpr_merged;
    logic [31:0] gpr_view;
    opsize_e     eff_size;
    assign eff_size = legal_size(gpr_sel, gpr_size);
    gpr_merge u_merge (
        .cur    (gpr_q[gpr_sel]),
        .wdata  (gpr_wdata),
        .size   (eff_size),
        .merged (gpr_merged),
        .view   (gpr_view)
    );

    // Register file writes; execution port has priority over software
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                gpr_q[i] <= `GPR_RST;
            end
        end else if (clk_en) begin
            if (gpr_wr) begin
                gpr_q[gpr_sel] <= gpr_merged;
                if (gpr_pair && eff_size == sz_dword) begin
                    gpr_q[io_data_reg] <= gpr_wdata;
                end
            end else if (sw_wr && in_range(sw_addr, `GPR_BASE, 6'd8)) begin
                gpr_q[sw_addr[2:0]] <= sw_wdata;
            end
        end
    end

    // Segment register writes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 6; i++) begin
                seg_q[i] <= `SEG_RST;
            end
        end else if (clk_en) begin
            if (seg_wr && seg_sel < 3'd6) begin
                seg_q[seg_sel] <= seg_wdata;
            end else if (sw_wr && in_range(sw_addr, `SEG_BASE, 6'd6)) begin
                seg_q[sw_addr[2:0]] <= sw_wdata[15:0];
            end
        end
    end

    // Mode bits: protected mode and 32-bit pointer form
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prot_q <= 1'b0;
            op32_q <= 1'b0;
        end else if (clk_en && sw_wr && sw_addr == `MODE_OFF) begin
            prot_q <= sw_wdata[0];
            op32_q <= sw_wdata[1];
        end
    end

    // Instruction pointer: no plain data write path, only flow changes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ip_q <= `IPTR_RST;
        end else if (clk_en) begin
            case (ip_op)
                ip_advance: begin
                    ip_q <= op32_q ? ip_q + {28'h0, ip_len}
                                   : {16'h0000, ip_q[15:0] + {12'h000, ip_len}};
                end
                ip_transfer: begin
                    ip_q <= op32_q ? ip_target : {16'h0000, ip_target[15:0]};
                end
                default: begin
                    ip_q <= ip_q;
                end
            endcase
        end
    end

    // Float data registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                fpr_q[i] <= `FPR_RST;
            end
        end else if (clk_en && fpr_wr) begin
            fpr_q[fpr_sel] <= fpr_wdata;
        end
    end

    // Float status, control and tag words
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fsw_q <= `FSW_RST;
            fcw_q <= `FCW_RST;
            ftw_q <= `FTW_RST;
        end else if (clk_en) begin
            if (fsw_wr) begin
                fsw_q <= fsw_wdata;
            end
            if (sw_wr && sw_addr == `FCW_OFF) begin
                fcw_q <= sw_wdata[15:0];
            end
            if (ftw_wr) begin
                ftw_q <= ftw_wdata;
            end
        end
    end

    // Segment choice per reference kind
    logic [31:0] ref_off;
    logic [2:0]  ref_seg;
    always_comb begin
        case (ref_kind)
            use_fetch: begin
                ref_seg = code_segment;
                ref_off = ip_q;
            end
            use_stack: begin
                ref_seg = stack_segment;
                ref_off = gpr_q[stack_top_pointer];
            end
            use_src: begin
                ref_seg = data_segment;
                ref_off = gpr_q[source_index_reg];
            end
            default: begin
                ref_seg = extra_data_segment;
                ref_off = gpr_q[dest_index_reg];
            end
        endcase
    end

    seg_xlate_if xif ();
    assign xif.prot_mode  = prot_q;
    assign xif.seg_value  = seg_q[ref_seg];
    assign xif.offset     = ref_off;
    assign xif.desc_base  = desc_base;
    assign xif.desc_limit = desc_limit;
    assign xif.desc_attr  = desc_attr;
    seg_xlate u_xlate (
        .x (xif.translator)
    );

    // Registered outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lin_addr   <= 32'h0000_0000;
            desc_index <= 13'h0000;
            addr_fault <= 1'b0;
            fetch_addr <= 32'h0000_0000;
            gpr_rdata  <= 64'h0;
            fpr_rdata  <= `FPR_RST;
            fcw_out    <= `FCW_RST;
        end else if (clk_en) begin
            lin_addr   <= xif.lin_addr;
            desc_index <= xif.desc_index;
            addr_fault <= xif.limit_fault;
            fetch_addr <= ip_q;
            gpr_rdata  <= (gpr_pair && eff_size == sz_dword) ? {gpr_q[io_data_reg], gpr_view}
                                                            : {32'h0, gpr_view};
            fpr_rdata  <= fpr_q[fpr_sel];
            fcw_out    <= fcw_q;
        end
    end

    // Software read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sw_rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (!sw_rd) begin
                sw_rdata <= 32'h0000_0000;
            end else if (in_range(sw_addr, `GPR_BASE, 6'd8)) begin
                sw_rdata <= gpr_q[sw_addr[2:0]];
            end else if (in_range(sw_addr, `SEG_BASE, 6'd6)) begin
                sw_rdata <= {16'h0000, seg_q[sw_addr[2:0]]};
            end else if (in_range(sw_addr, `FPR_BASE, 6'd24)) begin
                // Each float register spans three words, low word first
                sw_rdata <= fpr_word(sw_addr - `FPR_BASE);
            end else begin
                case (sw_addr)
                    `IPTR_OFF: sw_rdata <= ip_q;
                    `MODE_OFF: sw_rdata <= {30'h0, op32_q, prot_q};
                    `FSW_OFF:  sw_rdata <= {16'h0000, fsw_q};
                    `FCW_OFF:  sw_rdata <= {16'h0000, fcw_q};
                    `FTW_OFF:  sw_rdata <= {16'h0000, ftw_q};
                    default:   sw_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Word select within the float register window
    function automatic logic [31:0] fpr_word(input logic [5:0] idx);
        logic [2:0] r;
        logic [1:0] w;
        logic [95:0] wide;
        r    = 3'(idx / 6'd3);
        w    = 2'(idx % 6'd3);
        wide = {16'h0000, fpr_q[r]};
        return wide[32*w +: 32];
    endfunction : fpr_word
endmodule : arch_regs

// ==== verification/arch_regs_checker.sv ====
// Port-level assertions for the architectural register set
`include "arch_regs_cfg.svh"
module arch_regs_checker
    import arch_regs_pkg::*;
(
    // Clock and reset
    input wire logic                   clk_sys,
    input wire logic                   rst,
    input wire logic                   clk_en,
    // Software port
    input wire logic [5:0]             sw_addr,
    input wire logic [31:0]            sw_wdata,
    input wire logic                   sw_wr,
    input wire logic                   sw_rd,
    input wire logic [31:0]            sw_rdata,
    // Integer port
    input wire logic [2:0]             gpr_sel,
    input wire arch_regs_pkg::opsize_e gpr_size,
    input wire logic                   gpr_wr,
    input wire logic [31:0]            gpr_wdata,
    input wire logic                   gpr_pair,
    input wire logic [63:0]            gpr_rdata,
    // Address, pointer and control word
    input wire logic [7:0]             desc_attr,
    input wire logic                   addr_fault,
    input wire arch_regs_pkg::ip_op_e  ip_op,
    input wire logic [31:0]            ip_target,
    input wire logic [31:0]            fetch_addr,
    input wire logic [15:0]            fcw_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic prot_q;
    // Mirror of the mode bit; fault checks depend on it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prot_q <= 1'b0;
        end else if (clk_en && sw_wr && sw_addr == `MODE_OFF) begin
            prot_q <= sw_wdata[0];
        end
    end
    // Write, then the same view read in the next cycle
    sequence wr_rd;
        gpr_wr && clk_en && !gpr_pair ##1
        clk_en && !gpr_wr && !gpr_pair && gpr_sel == $past(gpr_sel) && gpr_size == $past(gpr_size);
    endsequence
    a_dword_store: assert property ((gpr_size == sz_dword) ##0 wr_rd |=>
        gpr_rdata == {32'h0, $past(gpr_wdata, 2)}) else $error("dword view lost");
    a_word_view: assert property ((gpr_size == sz_word) ##0 wr_rd |=>
        gpr_rdata == {48'h0, $past(gpr_wdata[15:0], 2)}) else $error("word view wrong");
    a_byte_high: assert property ((gpr_size == sz_byte_hi && gpr_sel < 3'h4) ##0 wr_rd |=>
        gpr_rdata == {56'h0, $past(gpr_wdata[7:0], 2)}) else $error("high byte view wrong");
    a_fcw_write: assert property (clk_en && sw_wr && sw_addr == `FCW_OFF |=> ##1
        fcw_out == $past(sw_wdata[15:0], 2)) else $error("control word not written");
    a_fcw_read: assert property (clk_en && sw_rd && sw_addr == `FCW_OFF |=>
        sw_rdata == {16'h0, fcw_out}) else $error("control word read wrong");
    a_ip_freeze: assert property (!clk_en [*2] |=> $stable(fetch_addr))
        else $error("pointer moved while frozen");
    a_ip_jump: assert property (clk_en && ip_op == ip_transfer && ip_target[31:16] == 16'h0 |-> ##2
        fetch_addr == $past(ip_target, 2)) else $error("transfer target missed");
    a_prot_fault: assert property (prot_q && clk_en && !desc_attr[7] |=> addr_fault)
        else $error("absent descriptor not faulted");
    a_real_clean: assert property (!prot_q && clk_en |=> !addr_fault)
        else $error("fault in real mode");
    // Main scenarios reached
    c_fault: cover property (prot_q && addr_fault);
    c_byte: cover property (gpr_wr && gpr_size == sz_byte_hi);
    c_jump: cover property (ip_op == ip_transfer ##1 ip_op == ip_advance);
endmodule : arch_regs_checker

// ==== verification/exec_model.sv ====
// Execution-side model driving the integer and float register ports
module exec_model
    import arch_regs_pkg::*;
(
    // Clock
    input  wire logic                   clk_sys,
    // Integer port
    output logic [2:0]                  gpr_sel,
    output arch_regs_pkg::opsize_e      gpr_size,
    output logic                        gpr_wr,
    output logic [31:0]                 gpr_wdata,
    output logic                        gpr_pair,
    input  wire logic [63:0]            gpr_rdata,
    // Float port
    output logic [2:0]                  fpr_sel,
    output logic                        fpr_wr,
    output arch_regs_pkg::fpr_t         fpr_wdata,
    input  wire arch_regs_pkg::fpr_t    fpr_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet ports at time zero
    initial begin
        {gpr_sel, gpr_wr, gpr_wdata, gpr_pair, fpr_sel, fpr_wr, fpr_wdata} = '0;
        gpr_size = sz_dword;
    end
    // One integer access; the view is returned one edge later
    task automatic gop(input logic w, input logic [2:0] s, input opsize_e z, input logic p,
                       input logic [31:0] d, output logic [63:0] r);
        @(posedge clk_sys);
        gpr_sel <= s;
        gpr_size <= z;
        gpr_pair <= p;
        gpr_wdata <= d;
        gpr_wr <= w;
        @(posedge clk_sys);
        gpr_wr <= 1'b0;
        gpr_wdata <= ~d; // Released data never shows a stale value
        #1 r = gpr_rdata;
    endtask : gop
    // One float register access
    task automatic fop(input logic w, input logic [2:0] s, input fpr_t d, output fpr_t r);
        @(posedge clk_sys);
        fpr_sel <= s;
        fpr_wdata <= d;
        fpr_wr <= w;
        @(posedge clk_sys);
        fpr_wr <= 1'b0;
        fpr_wdata <= ~d;
        #1 r = fpr_rdata;
    endtask : fop
endmodule : exec_model

// ==== verification/tb.sv ====
// Self-checking bench for the architectural register set
`include "arch_regs_cfg.svh"
module tb
    import arch_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Bench-driven and observed signals
    logic        clk_sys, rst, clk_en, sw_wr, sw_rd, seg_wr, fsw_wr, ftw_wr, gpr_wr, gpr_pair, fpr_wr, addr_fault;
    logic [5:0]  sw_addr;
    logic [31:0] sw_wdata, desc_base, desc_limit, ip_target, gpr_wdata, sw_rdata, lin_addr, fetch_addr, w;
    logic [2:0]  seg_sel, gpr_sel, fpr_sel;
    logic [15:0] seg_wdata, fsw_wdata, ftw_wdata, fcw_out;
    logic [7:0]  desc_attr;
    logic [3:0]  ip_len;
    logic [12:0] desc_index;
    logic [63:0] gpr_rdata, r;
    ref_kind_e   ref_kind;
    ip_op_e      ip_op;
    opsize_e     gpr_size;
    fpr_t        fpr_wdata, fpr_rdata, f;
    int          num_errors = 0;
    int          n_tests = 0;
    arch_regs arch_regs_i (.clk_sys, .rst, .clk_en, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata,
        .gpr_sel, .gpr_size, .gpr_wr, .gpr_wdata, .gpr_pair, .gpr_rdata, .seg_sel, .seg_wr, .seg_wdata,
        .ref_kind, .desc_base, .desc_limit, .desc_attr, .lin_addr, .desc_index, .addr_fault, .ip_op,
        .ip_len, .ip_target, .fetch_addr, .fpr_sel, .fpr_wr, .fpr_wdata, .fpr_rdata, .fsw_wr,
        .fsw_wdata, .ftw_wr, .ftw_wdata, .fcw_out);
    exec_model exec_model_i (.clk_sys, .gpr_sel, .gpr_size, .gpr_wr, .gpr_wdata, .gpr_pair,
        .gpr_rdata, .fpr_sel, .fpr_wr, .fpr_wdata, .fpr_rdata);
    task automatic chk(input logic [79:0] g, input logic [79:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Register bus master: one-cycle strobes
    task automatic swr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk_sys);
        sw_wr <= 1'b0;
    endtask : swr
    task automatic srd(input logic [5:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk_sys);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask : srd
    task automatic segw(input logic [2:0] s, input logic [15:0] d);
        @(posedge clk_sys);
        seg_sel <= s;
        seg_wdata <= d;
        seg_wr <= 1'b1;
        @(posedge clk_sys);
        seg_wr <= 1'b0;
    endtask : segw
    task automatic t_views;
        exec_model_i.gop(1'b1, 3'h0, sz_dword, 1'b0, 32'h1122_3344, r);
        exec_model_i.gop(1'b1, 3'h0, sz_byte_hi, 1'b0, 32'h0000_00ab, r);
        exec_model_i.gop(1'b1, 3'h0, sz_byte_lo, 1'b0, 32'h0000_00cd, r);
        exec_model_i.gop(1'b0, 3'h0, sz_dword, 1'b0, 32'h0, r);
        chk(r, 64'h1122_abcd);
        exec_model_i.gop(1'b1, 3'h0, sz_word, 1'b0, 32'hffff_5566, r);
        srd(`GPR_BASE, w);
        chk(w, 32'h1122_5566);
        exec_model_i.gop(1'b1, 3'h4, sz_dword, 1'b0, 32'h89ab_cdef, r);
        exec_model_i.gop(1'b1, 3'h4, sz_byte_hi, 1'b0, 32'h0000_1234, r);
        exec_model_i.gop(1'b0, 3'h4, sz_dword, 1'b0, 32'h0, r);
        chk(r, 64'h89ab_1234);
        exec_model_i.gop(1'b1, 3'h2, sz_dword, 1'b0, 32'h0bad_f00d, r);
        exec_model_i.gop(1'b1, 3'h3, sz_dword, 1'b0, 32'h1357_9bdf, r);
        exec_model_i.gop(1'b0, 3'h3, sz_dword, 1'b1, 32'h0, r);
        chk(r, 64'h0bad_f00d_1357_9bdf);
        $display("views test done");
    endtask : t_views
    task automatic t_seg;
        logic [2:0]  sn[4] = '{3'h1, 3'h2, 3'h3, 3'h0};
        logic [2:0]  gn[4] = '{3'h0, 3'h4, 3'h6, 3'h7};
        logic [15:0] sv[4] = '{16'h0300, 16'h0200, 16'h1234, 16'h0100};
        logic [31:0] ofs[4] = '{32'h0, 32'h10, 32'h20, 32'h8};
        for (int k = 0; k < 4; k++) begin
            segw(sn[k], sv[k]);
            if (k > 0) exec_model_i.gop(1'b1, gn[k], sz_dword, 1'b0, ofs[k], r);
            @(posedge clk_sys);
            ref_kind <= ref_kind_e'(k);
            @(posedge clk_sys);
            #1 chk(lin_addr, {12'h0, sv[k], 4'h0} + ofs[k]);
        end
        srd(`SEG_BASE + 6'h3, w);
        chk(w, 32'h1234);
        swr(`MODE_OFF, 32'h3);
        desc_base <= 32'h4000_0000;
        desc_limit <= 32'h1f;
        desc_attr <= 8'h80;
        ref_kind <= use_src;
        @(posedge clk_sys);
        #1 chk(addr_fault, 1'b1);
        desc_limit <= 32'hff;
        @(posedge clk_sys);
        #1 chk({desc_index, addr_fault, lin_addr}, {13'h0246, 1'b0, 32'h4000_0020});
        desc_attr <= 8'h00;
        @(posedge clk_sys);
        #1 chk(addr_fault, 1'b1);
        swr(`MODE_OFF, 32'h2);
        $display("segment test done");
    endtask : t_seg
    task automatic t_ip;
        ip_target <= 32'h0001_0100;
        ip_op <= ip_transfer;
        @(posedge clk_sys);
        ip_op <= ip_advance;
        ip_len <= 4'h3;
        @(posedge clk_sys);
        clk_en <= 1'b0;
        repeat (2) @(posedge clk_sys);
        clk_en <= 1'b1;
        ip_op <= ip_hold;
        swr(`IPTR_OFF, 32'hdead);
        srd(`IPTR_OFF, w);
        chk({w, fetch_addr}, {32'h0001_0103, 32'h0001_0103});
        swr(`MODE_OFF, 32'h0);
        ip_target <= 32'h0000_fffe;
        ip_op <= ip_transfer;
        @(posedge clk_sys);
        ip_op <= ip_advance;
        @(posedge clk_sys);
        ip_op <= ip_hold;
        @(posedge clk_sys);
        #1 chk(fetch_addr, 32'h0000_0001);
        $display("pointer test done");
    endtask : t_ip
    task automatic t_fpu;
        exec_model_i.fop(1'b1, 3'h5, 80'hc00a_1234_5678_9abc_def0, f);
        exec_model_i.fop(1'b0, 3'h5, 80'h0, f);
        chk(f, 80'hc00a_1234_5678_9abc_def0);
        for (int k = 0; k < 3; k++) begin
            srd(6'h2f + 6'(k), w);
            chk(w, 32'({16'h0, 80'hc00a_1234_5678_9abc_def0} >> (32 * k)));
        end
        fsw_wr <= 1'b1;
        ftw_wr <= 1'b1;
        fsw_wdata <= 16'h3800;
        ftw_wdata <= 16'h5555;
        @(posedge clk_sys);
        fsw_wr <= 1'b0;
        ftw_wr <= 1'b0;
        swr(`FSW_OFF, 32'h1);
        srd(`FSW_OFF, w);
        chk(w, 32'h3800);
        srd(`FTW_OFF, w);
        chk(w, 32'h5555);
        swr(`FCW_OFF, 32'h037f);
        srd(`FCW_OFF, w);
        chk({w, fcw_out}, {32'h037f, 16'h037f});
        swr(6'h3f, 32'hffff_ffff);
        srd(6'h3f, w);
        chk(w, 32'h0);
        $display("float test done");
    endtask : t_fpu
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Reset, then the scenarios in turn
    initial begin
        {sw_wr, sw_rd, seg_wr, fsw_wr, ftw_wr, sw_addr, sw_wdata, seg_sel, seg_wdata} = '0;
        {desc_base, desc_limit, desc_attr, ip_target, ip_len, fsw_wdata, ftw_wdata} = '0;
        ref_kind = use_fetch;
        ip_op = ip_hold;
        clk_en = 1'b1;
        rst = 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        srd(`FTW_OFF, w);
        chk(w, 32'hffff);
        t_views();
        t_seg();
        t_ip();
        t_fpu();
        give_verdict();
    end
    // Watchdog well beyond the hundred or so cycles the run needs
    initial begin
        #100us;
        num_errors++;
        $display("[ERR] %0t got %h exp %h", $time, 1'b0, 1'b1);
        give_verdict();
    end
endmodule : tb
bind arch_regs arch_regs_checker arch_regs_checker_i (.clk_sys, .rst, .clk_en, .sw_addr, .sw_wdata,
    .sw_wr, .sw_rd, .sw_rdata, .gpr_sel, .gpr_size, .gpr_wr, .gpr_wdata, .gpr_pair, .gpr_rdata,
    .desc_attr, .addr_fault, .ip_op, .ip_target, .fetch_addr, .fcw_out);
